// >>> hdl/irq_aggregator_groups_13_14.sv
// interrupt aggregation groups a and b with controller register access
// Operation
// R1: every source bit has enable and result; here only group a has them, group b enable is tied to zero
// R2: group a latch at 64h, write-one-clear
// R3: group a enable at 68h, defined bits only
// R4: result bits 30:0 read-only, bit 31 storage
// R5: host pm register writes set bits 0-2
// R6: dma channel 7..0 map to bits 16..23
// R7: reserved bits never set, never wake
// R8: group b latch at 78h, write-one-clear
// R9: bit 0 follows host bus powerdown event
// R10: bit 1 set on host bus reset assert
// R11: bit 2 set on host access error
// R12: bits 3,4 controller serial empty/full
// R13: bits 5-7 flash busy/command/protect errors
// R14: bit 8 flash handover interrupt from host
// R15: bit 9 main power good from pin
// R16: bits 16,17 host serial empty/full
// R17: bit 18 companion interface interrupt
// R18: all registers clear on system reset
// R19: result is latch AND enable; irq ORs
`timescale 1ns/100ps
module irq_aggregator_groups_13_14
    import irq_aggregator_pkg::*;
(
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire irq_aggregator_pkg::bus_req_t      busReq,
    output logic [irq_aggregator_pkg::DATA_W-1:0]  busRdata,
    input  wire irq_aggregator_pkg::group_a_src_t  groupASrc,
    input  wire irq_aggregator_pkg::group_b_src_t  groupBSrc,
    output logic                                   groupAIrq,
    output logic                                   groupAWake,
    output logic [irq_aggregator_pkg::DATA_W-1:0]  groupBEnable,
    output logic [irq_aggregator_pkg::DATA_W-1:0]  groupBLatch,
    output logic                                   groupBWake
);
    import irq_aggregator_pkg::*;

    // wake-capable group b positions
    localparam logic [DATA_W-1:0] GROUP_B_WAKE = 32'h0000_0203;

    agg_state_t stateReg;
    agg_state_t stateNext;

    logic [DATA_W-1:0] setA;
    logic [DATA_W-1:0] setB;
    logic [DATA_W-1:0] resultA;

    function automatic logic hit(input bus_req_t req, input logic [ADDR_W-1:0] ofs);
        hit = req.addr == ofs;
    endfunction : hit

    // group a event vector
    always_comb
    begin
        setA = ALL_ZERO;
        setA[PM_CTL_BIT] = groupASrc.pmControlTwoWritten; // R5
        setA[PM_EN_BIT]  = groupASrc.pmEnableTwoWritten;  // R5
        setA[PM_STS_BIT] = groupASrc.pmStatusTwoWritten;  // R5
        for (int ch = 0; ch < DMA_CHANNELS; ch++)
        begin
            setA[DMA_BASE_BIT + DMA_CHANNELS - 1 - ch] = groupASrc.dmaDone[ch]; // R6
        end
        setA = setA & GROUP_A_DEFINED; // R7
    end

    // group b event vector; pin levels use only the second sync stage
    always_comb
    begin
        setB = ALL_ZERO;
        // powerdown event taken as the falling edge of the active-low pin state
        setB[PD_BIT]        = stateReg.pdPrev & ~stateReg.pdSync[1]; // R9
        setB[RST_BIT]       = stateReg.rstPrev & ~stateReg.rstSync[1]; // R10
        setB[ACC_ERR_BIT]   = groupBSrc.hostAccessError; // R11
        setB[CTX_EMPTY_BIT] = groupBSrc.ctrlSerialTxEmpty; // R12
        setB[CRX_FULL_BIT]  = groupBSrc.ctrlSerialRxFull; // R12
        setB[FL_BUSY_BIT]   = groupBSrc.eflashBusyErr; // R13
        setB[FL_CMD_BIT]    = groupBSrc.eflashCmdErr; // R13
        setB[FL_PROT_BIT]   = groupBSrc.eflashProtErr; // R13
        setB[FL_HAND_BIT]   = groupBSrc.eflashHandoverIrq; // R14
        setB[PWRGD_BIT]     = stateReg.pgSync[1]; // R15
        setB[HTX_EMPTY_BIT] = groupBSrc.hostSerialTxEmpty; // R16
        setB[HRX_FULL_BIT]  = groupBSrc.hostSerialRxFull; // R16
        setB[COMP_BIT]      = groupBSrc.companionIfIrq; // R17
        setB = setB & GROUP_B_DEFINED; // R7
    end

    assign resultA = stateReg.latchA & stateReg.enableA & GROUP_A_DEFINED; // R1 R19

    always_comb
    begin
        logic [DATA_W-1:0] clrA;
        logic [DATA_W-1:0] clrB;
        clrA = ALL_ZERO;
        clrB = ALL_ZERO;
        stateNext = stateReg;

        stateNext.pdSync  = {stateReg.pdSync[0], groupBSrc.hostBusPowerdown_n};
        stateNext.pdPrev  = stateReg.pdSync[1];
        stateNext.rstSync = {stateReg.rstSync[0], groupBSrc.hostBusReset_n};
        stateNext.rstPrev = stateReg.rstSync[1];
        stateNext.pgSync  = {stateReg.pgSync[0], groupBSrc.mainPowerGoodIrq};

        if (busReq.wrEn)
        begin
            if (hit(busReq, GROUP_A_LATCH_OFS))
            begin
                clrA = busReq.wdata & GROUP_A_DEFINED; // R2
            end
            if (hit(busReq, GROUP_A_ENABLE_OFS))
            begin
                stateNext.enableA = busReq.wdata & GROUP_A_DEFINED; // R3
            end
            if (hit(busReq, GROUP_A_RESULT_OFS))
            begin
                stateNext.normalizeHelperA = busReq.wdata[NORMALIZE_BIT]; // R4
            end
            if (hit(busReq, GROUP_B_LATCH_OFS))
            begin
                clrB = busReq.wdata & GROUP_B_DEFINED; // R8
            end
        end

        // a new event wins over a clear in the same cycle
        stateNext.latchA = ((stateReg.latchA & ~clrA) | setA) & GROUP_A_DEFINED; // R2 R7
        stateNext.latchB = ((stateReg.latchB & ~clrB) | setB) & GROUP_B_DEFINED; // R8 R7

        stateNext.rdata = ALL_ZERO;
        if (busReq.rdEn)
        begin
            case (busReq.addr)
                GROUP_A_LATCH_OFS:  stateNext.rdata = stateReg.latchA;
                GROUP_A_ENABLE_OFS: stateNext.rdata = stateReg.enableA;
                GROUP_A_RESULT_OFS:
                begin
                    stateNext.rdata = resultA; // R4
                    stateNext.rdata[NORMALIZE_BIT] = stateReg.normalizeHelperA; // R4
                end
                GROUP_B_LATCH_OFS:  stateNext.rdata = stateReg.latchB;
                default:            stateNext.rdata = ALL_ZERO;
            endcase
        end
    end

    // registers sit on standby power; cleared only by system reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stateReg <= '0; // R18
        end
        else
        begin
            stateReg <= stateNext;
        end
    end

    assign busRdata     = stateReg.rdata;
    assign groupAIrq    = |resultA; // R19
    // no group a source is wake-capable
    assign groupAWake   = 1'b0; // R5 R6
    assign groupBLatch  = stateReg.latchB;
    // enable and result of group b live elsewhere; wake is offered unmasked
    assign groupBEnable = ALL_ZERO;
    assign groupBWake   = |(stateReg.latchB & GROUP_B_WAKE); // R9 R10 R15 R7

endmodule : irq_aggregator_groups_13_14

// >>> hdl/irq_aggregator_pkg.sv
// constants and types for the two interrupt aggregation groups
package irq_aggregator_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] GROUP_A_LATCH_OFS  = 8'h64;
    localparam logic [ADDR_W-1:0] GROUP_A_ENABLE_OFS = 8'h68;
    localparam logic [ADDR_W-1:0] GROUP_A_RESULT_OFS = 8'h6C;
    localparam logic [ADDR_W-1:0] GROUP_B_LATCH_OFS  = 8'h78;

    localparam logic [DATA_W-1:0] GROUP_A_DEFINED = 32'h00FF_0007;
    localparam logic [DATA_W-1:0] GROUP_B_DEFINED = 32'h0007_03FF;
    localparam logic [DATA_W-1:0] ALL_ZERO        = 32'h0000_0000;

    localparam int NORMALIZE_BIT  = 31;
    localparam int DMA_BASE_BIT   = 16;
    localparam int DMA_CHANNELS   = 8;
    localparam int PM_CTL_BIT     = 0;
    localparam int PM_EN_BIT      = 1;
    localparam int PM_STS_BIT     = 2;
    localparam int PD_BIT         = 0;
    localparam int RST_BIT        = 1;
    localparam int ACC_ERR_BIT    = 2;
    localparam int CTX_EMPTY_BIT  = 3;
    localparam int CRX_FULL_BIT   = 4;
    localparam int FL_BUSY_BIT    = 5;
    localparam int FL_CMD_BIT     = 6;
    localparam int FL_PROT_BIT    = 7;
    localparam int FL_HAND_BIT    = 8;
    localparam int PWRGD_BIT      = 9;
    localparam int HTX_EMPTY_BIT  = 16;
    localparam int HRX_FULL_BIT   = 17;
    localparam int COMP_BIT       = 18;

    // register access from the controller
    typedef struct packed {
        logic              wrEn;
        logic              rdEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

    // group a event sources
    typedef struct packed {
        logic                    pmControlTwoWritten;
        logic                    pmEnableTwoWritten;
        logic                    pmStatusTwoWritten;
        logic [DMA_CHANNELS-1:0] dmaDone;
    } group_a_src_t;

    // group b event sources, raw levels and strobes
    typedef struct packed {
        logic hostBusPowerdown_n;
        logic hostBusReset_n;
        logic hostAccessError;
        logic ctrlSerialTxEmpty;
        logic ctrlSerialRxFull;
        logic eflashBusyErr;
        logic eflashCmdErr;
        logic eflashProtErr;
        logic eflashHandoverIrq;
        logic mainPowerGoodIrq;
        logic hostSerialTxEmpty;
        logic hostSerialRxFull;
        logic companionIfIrq;
    } group_b_src_t;

    typedef struct packed {
        logic [DATA_W-1:0] latchA;
        logic [DATA_W-1:0] enableA;
        logic              normalizeHelperA;
        logic [DATA_W-1:0] latchB;
        logic [1:0]        pdSync;
        logic              pdPrev;
        logic [1:0]        rstSync;
        logic              rstPrev;
        logic [1:0]        pgSync;
        logic [DATA_W-1:0] rdata;
    } agg_state_t;

endpackage : irq_aggregator_pkg

// >>> bench/irq_agg_assertions.sv
// port assertions for the interrupt aggregator
`timescale 1ns/100ps
module irq_agg_assertions
    import irq_aggregator_pkg::*;
(
    input wire logic                             clk,
    input wire logic                             rst_n,
    input wire irq_aggregator_pkg::bus_req_t     busReq,
    input wire logic [DATA_W-1:0]                busRdata,
    input wire irq_aggregator_pkg::group_b_src_t groupBSrc,
    input wire logic                             groupAIrq,
    input wire logic [DATA_W-1:0]                groupBLatch,
    input wire logic                             groupBWake
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_A_RSVD:
        assert property (busReq.rdEn && busReq.addr inside {8'h64, 8'h68} |=>
            (busRdata & ~GROUP_A_DEFINED) == ALL_ZERO) else $error("reserved a bit read");
    AST_B_RSVD:
        assert property ((groupBLatch & ~GROUP_B_DEFINED) == ALL_ZERO) else $error("reserved b");
    AST_ACC_ERR:
        assert property (groupBSrc.hostAccessError |=> groupBLatch[2]) else $error("bit 2 unset");
    // set wins, so only a quiet source may be cleared
    AST_CLEAR:
        assert property (busReq.wrEn && busReq.addr == 8'h78 && busReq.wdata[2]
            && !groupBSrc.hostAccessError |=> !groupBLatch[2]) else $error("bit 2 kept");
    AST_WAKE:
        assert property (groupBWake == |(groupBLatch & 32'h0000_0203)) else $error("wake");
    AST_RST_EDGE:
        assert property ($fell(groupBSrc.hostBusReset_n) |-> ##[1:4] groupBLatch[1])
            else $error("bit 1 unset");
    // two sync stages plus the latch
    AST_PWRGD:
        assert property (groupBSrc.mainPowerGoodIrq [*4] |-> groupBLatch[9]) else $error("bit 9");
    AST_IRQ:
        assert property (busReq.rdEn && busReq.addr == 8'h6C |=>
            (|busRdata[30:0]) == $past(groupAIrq)) else $error("irq vs result");
endmodule : irq_agg_assertions

// >>> bench/cpu_model.sv
// controller core model issuing register accesses
`timescale 1ns/100ps
module cpu_model
    import irq_aggregator_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic [DATA_W-1:0]       busRdata,
    output irq_aggregator_pkg::bus_req_t busReq
);
    initial busReq = '0;
    // called just after an edge; spare cycle so no strobe is set twice in one step
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        busReq <= '{wrEn: wr, rdEn: !wr, addr: a, wdata: d};
        @(posedge clk);
        #1 busReq <= '0;
        q = busRdata;
        @(posedge clk);
        #1;
    endtask : xfer
endmodule : cpu_model

// >>> bench/tb_irq_aggregator_groups_13_14.sv
// self-checking bench for the interrupt aggregation groups
`timescale 1ns/100ps
module tb_irq_aggregator_groups_13_14;
    import irq_aggregator_pkg::*;
    localparam logic [23:0] IDLE = 24'h001800;
    logic              clk, rst_n, groupAIrq, groupAWake, groupBWake;
    bus_req_t          busReq;
    logic [DATA_W-1:0] busRdata, groupBEnable, groupBLatch, q;
    group_a_src_t      aSrc;
    group_b_src_t      bSrc;
    int                nErrors, checksDone;
    logic [7:0]        regs [5] = '{8'h64, 8'h68, 8'h6C, 8'h78, 8'h70};
    // row: {group a, group b} sources, offset read, value expected
    logic [63:0] rows [18] = '{64'h801800_64_00000001, 64'h401800_6C_00000002,
        64'h201800_64_00000004, 64'h003800_6C_00800000, 64'h101800_64_00010000,
        64'h000800_78_00000001, 64'h001000_78_00000002, 64'h001C00_78_00000004,
        64'h001A00_78_00000008, 64'h001900_78_00000010, 64'h001880_78_00000020,
        64'h001840_78_00000040, 64'h001820_78_00000080, 64'h001810_78_00000100,
        64'h001808_78_00000200, 64'h001804_78_00010000, 64'h001802_78_00020000,
        64'h001801_78_00040000};
    irq_aggregator_groups_13_14 i_irq_aggregator_groups_13_14 (.clk(clk), .rst_n(rst_n),
        .busReq(busReq), .busRdata(busRdata), .groupASrc(aSrc), .groupBSrc(bSrc),
        .groupAIrq(groupAIrq), .groupAWake(groupAWake), .groupBEnable(groupBEnable),
        .groupBLatch(groupBLatch), .groupBWake(groupBWake));
    cpu_model i_cpu_model (.clk(clk), .busRdata(busRdata), .busReq(busReq));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            nErrors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd(input logic [ADDR_W-1:0] a);
        i_cpu_model.xfer(1'b0, a, ALL_ZERO, q);
    endtask : rd
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        i_cpu_model.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic giveVerdict();
        $display("checks %0d errors %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : giveVerdict
    initial
    begin
        rst_n = 1'b0;
        {aSrc, bSrc} = IDLE;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        foreach (regs[k])
        begin
            rd(regs[k]);
            chk(q, ALL_ZERO);
        end
        wr(8'h68, '1);
        rd(8'h68);
        chk(q, GROUP_A_DEFINED);
        foreach (rows[i])
        begin
            {aSrc, bSrc} = rows[i][63:40];
            repeat (5) @(posedge clk);
            #1 {aSrc, bSrc} = IDLE;
            repeat (4) @(posedge clk);
            #1 rd(rows[i][39:32]);
            chk(q, rows[i][31:0]);
            wr(8'h64, '1);
            wr(8'h78, '1);
            chk(groupBLatch, ALL_ZERO);
        end
        aSrc = '1;
        bSrc = 13'h07FF;
        repeat (5) @(posedge clk);
        #1 {aSrc, bSrc} = IDLE;
        rd(8'h64);
        chk(q, GROUP_A_DEFINED);
        chk(groupBLatch, GROUP_B_DEFINED);
        chk(groupAIrq, 1'b1);
        chk(groupBWake, 1'b1);
        chk(groupAWake, 1'b0);
        chk(groupBEnable, ALL_ZERO);
        wr(8'h64, 32'h0000_0001);
        wr(8'h78, 32'h0000_0203);
        rd(8'h64);
        chk(q, 32'h00FF_0006);
        chk(groupBLatch, 32'h0007_01FC);
        chk(groupBWake, 1'b0);
        wr(8'h68, ALL_ZERO);
        wr(8'h6C, '1);
        rd(8'h6C);
        chk(q, 32'h8000_0000);
        chk(groupAIrq, 1'b0);
        rst_n = 1'b0;
        #20 chk(groupBLatch, ALL_ZERO);
        @(posedge clk);
        #1 rst_n = 1'b1;
        rd(8'h6C);
        chk(q, ALL_ZERO);
        giveVerdict();
    end
    // the run needs about 330 cycles
    initial
    begin
        repeat (2000) @(posedge clk);
        nErrors++;
        giveVerdict();
    end
endmodule : tb_irq_aggregator_groups_13_14
bind irq_aggregator_groups_13_14 irq_agg_assertions i_irq_agg_assertions (.clk(clk),
    .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata), .groupBSrc(groupBSrc),
    .groupAIrq(groupAIrq), .groupBLatch(groupBLatch), .groupBWake(groupBWake));
